// [design/mdrs_pkg.sv]
// shared constants and carrier types for the motor drive supervisor
`default_nettype none
package mdrs_pkg;
   // ************************************************
   // clock and timing
   // ************************************************
   localparam int CLK_MHZ = 100;               // core clock rate
   localparam int DIP_FILTER_US = 20;           // supply dip filter
   localparam logic [11:0] DIP_FILTER_CYC =
      12'(DIP_FILTER_US * CLK_MHZ);
   localparam int RELEASE_DELAY_MS = 30;        // reset release delay
   localparam int unsigned RELEASE_DELAY_DEF =
      RELEASE_DELAY_MS * 1000 * CLK_MHZ;
   localparam int GAP_NS = 200;                 // crossover gap
   localparam logic [7:0] GAP_CYC =
      8'((GAP_NS * CLK_MHZ + 999) / 1000);
   localparam int BLANK_NS = 1000;              // sense blanking
   localparam logic [7:0] BLANK_CYC =
      8'((BLANK_NS * CLK_MHZ + 999) / 1000);
   localparam int CHOP_OFF_NS = 20000;          // chopper off time
   localparam logic [11:0] CHOP_OFF_CYC =
      12'((CHOP_OFF_NS * CLK_MHZ + 999) / 1000);

   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_DRIVE  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_AUX_ON = 0;              // aux regulator enable
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam int DRV_STRIDE = 8;               // bits per driver
   localparam int PH_STRIDE  = 3;               // bits per phase
   localparam int PH_LO  = 0;                   // phase_level_sel_lo
   localparam int PH_HI  = 1;                   // phase_level_sel_hi
   localparam int PH_POL = 2;                   // phase_polarity
   localparam int DRV_DC_DIR = 6;               // dc_rotation_bit
   localparam logic [15:0] DRIVE_RST = 16'h1B1B; // all phases off
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************
   // carrier types
   // ************************************************
   typedef struct packed {
      logic hs_a;                               // high side, half A
      logic ls_a;                               // low side, half A
      logic hs_b;                               // high side, half B
      logic ls_b;                               // low side, half B
   } gate_t;
   typedef struct packed {
      logic v1_above_rise;     // logic supply above rising threshold
      logic v1_below_fall;     // logic supply below falling threshold
      logic vb_ok;             // motor supply above its threshold
      logic vb_above_inhibit;  // motor supply at inhibit level or more
   } supply_t;
   localparam gate_t GATE_OFF   = 4'h0;
   localparam gate_t GATE_FWD   = 4'h9;         // hs_a and ls_b
   localparam gate_t GATE_REV   = 4'h6;         // ls_a and hs_b
   localparam gate_t GATE_BRAKE = 4'hA;         // both high sides
endpackage : mdrs_pkg
`default_nettype wire

// [design/motor_drive_reset_supervisor.sv]
// reset supervisor and two dual H-bridge drivers with AXI4-Lite regs
// How it works
// - both select bits set: phase off, fast decay
// - zero level opens all switches, current returns
// - crossover gap keeps half switches never both on
// - sense ignored for blanking after any turn-on
// - overtemperature forces stepper outputs to zero current
// - overtemperature drives both DC outputs high
// - DC drive uses chop pin and rotation bit
// - outputs inhibited while reset active above inhibit
// - reset low: outputs off, regs reset, aux on
// - open-drain active-low reset, pin sampled back
// - release only after delay from logic supply good
// - delay done: motor supply good releases immediately
// - motor good mid-delay: wait for delay end
// - hysteresis: release needs rising threshold
// - long logic dip below falling threshold asserts
// - motor supply low always asserts reset
// - short dip ignored, long dip gives full delay
// - each qualified dip restarts release delay
// - select code sets level, polarity sets sign
// - DC bridge follows chop and rotation table
// - aux regulator off disables both drivers
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none

// ************************************************
// one half bridge with crossover gap
// ************************************************
module half_gap
   import mdrs_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic want_hi,
   input  wire logic want_lo,
   output logic      hi,
   output logic      lo
);
   logic [7:0] gap_cnt;                  // remaining gap cycles
   wire logic  want_l = want_lo & ~want_hi; // high side wins a clash
   wire logic  change = {want_hi, want_l} != {hi, lo};

   // switches open at once, close only after the gap
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         hi      <= 1'b0;
         lo      <= 1'b0;
         gap_cnt <= 8'h00;
      end else if (change && (hi || lo)) begin
         hi      <= 1'b0;
         lo      <= 1'b0;
         gap_cnt <= GAP_CYC;
      end else if (gap_cnt != 8'h00) begin
         gap_cnt <= gap_cnt - 8'h01;
      end else if (change) begin
         hi <= want_hi;
         lo <= want_l;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   chk_gap_after_low: assert property (
      $fell(lo) |=> !hi [*8])
      else $error("high side closed too soon after low side");
   chk_gap_after_high: assert property (
      $fell(hi) |=> !lo [*8])
      else $error("low side closed too soon after high side");
endmodule : half_gap

// ************************************************
// top level
// ************************************************
module motor_drive_reset_supervisor
   import mdrs_pkg::*;
#(
   parameter int unsigned RELEASE_DELAY_CYC = RELEASE_DELAY_DEF
)(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire supply_t     supply,
   input  wire logic [1:0]  overtemp,
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   input  wire logic [1:0]  driver_type_select,
   input  wire logic [1:0]  dc_chop_input,
   input  wire logic [3:0]  sense_trip,
   output gate_t [3:0]      bridge_gate,
   output logic [7:0]       current_ref,
   output logic             aux_regulator_on
);
   // ************************************************
   // input synchronisers
   // ************************************************
   logic [14:0] sync_a;                 // first stage, read by b only
   logic [14:0] sync_b;                 // second stage, safe to use
   wire  logic [14:0] async_in = {sense_trip, dc_chop_input,
      driver_type_select, reset_pin_in, overtemp, supply};

   // two flops on every pin input
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync_a <= 15'h0000;
         sync_b <= 15'h0000;
      end else begin
         sync_a <= async_in;
         sync_b <= sync_a;
      end
   end

   wire supply_t    sup_s   = sync_b[3:0];
   wire logic [1:0] ot_s    = sync_b[5:4];
   wire logic       pin_s   = sync_b[6];
   wire logic [1:0] type_s  = sync_b[8:7];
   wire logic [1:0] chop_s  = sync_b[10:9];
   wire logic [3:0] sense_s = sync_b[14:11];

   // ************************************************
   // reset supervisor
   // ************************************************
   logic [11:0] dip_cnt;                // cycles below falling level
   logic        v1_good;                // logic supply qualified
   logic [31:0] delay_cnt;              // release delay timer

   // a dip counts only once it outlasts the filter
   wire logic dip_hit = sup_s.v1_below_fall &&
      (dip_cnt == DIP_FILTER_CYC - 12'h001);
   wire logic delay_done = (delay_cnt == RELEASE_DELAY_CYC);
   // any low cause holds the pin down
   wire logic next_reset_oe = !v1_good || !delay_done ||
      !sup_s.vb_ok;
   // pin read back covers external pull-downs
   wire logic reset_line_low = !pin_s || reset_pin_oe;
   // drive stopped during reset or with aux regulator off
   wire logic inhibit = reset_line_low ||
      !aux_regulator_on;

   assign reset_pin_out = 1'b0;          // open drain: only pulls low

   // dip filter counter, saturates at its terminal count
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         dip_cnt <= 12'h000;
      end else if (!sup_s.v1_below_fall) begin
         dip_cnt <= 12'h000;
      end else if (!dip_hit) begin
         dip_cnt <= dip_cnt + 12'h001;
      end
   end

   // hysteresis: a qualified dip clears, rising level sets
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         v1_good <= 1'b0;
      end else if (dip_hit) begin
         v1_good <= 1'b0;
      end else if (sup_s.v1_above_rise) begin
         v1_good <= 1'b1;
      end
   end

   // delay restarts on every qualified dip (one-shot retrigger)
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         delay_cnt <= 32'h0000_0000;
      end else if (!v1_good || dip_hit) begin
         delay_cnt <= 32'h0000_0000;
      end else if (!delay_done) begin
         delay_cnt <= delay_cnt + 32'h0000_0001;
      end
   end

   // pin enable registered; reset of the core also pulls low
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reset_pin_oe <= 1'b1;
      end else begin
         reset_pin_oe <= next_reset_oe;
      end
   end

   // ************************************************
   // register bus
   // ************************************************
   logic [15:0] drive_reg;              // phase and rotation fields
   wire  logic  aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire  logic  ar_take = s_axi_arvalid && !s_axi_rvalid;
   wire  logic  wr_ctrl  = aw_take && (s_axi_awaddr == ADDR_CTRL);
   wire  logic  wr_drive = aw_take && (s_axi_awaddr == ADDR_DRIVE);
   wire  logic  wr_hit = (s_axi_awaddr == ADDR_CTRL) ||
      (s_axi_awaddr == ADDR_DRIVE) || (s_axi_awaddr == ADDR_STATUS);
   wire  logic  rd_hit = (s_axi_araddr == ADDR_CTRL) ||
      (s_axi_araddr == ADDR_DRIVE) || (s_axi_araddr == ADDR_STATUS);
   wire  logic [31:0] status_word = {21'h000000, sup_s, type_s, ot_s,
      delay_done, v1_good, reset_line_low};
   wire  logic [31:0] rd_word =
      (s_axi_araddr == ADDR_CTRL)   ? {31'h00000000, aux_regulator_on} :
      (s_axi_araddr == ADDR_DRIVE)  ? {16'h0000, drive_reg} :
      (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0000_0000;

   // address and data taken together, one write at a time
   assign s_axi_awready = aw_take;
   assign s_axi_wready  = aw_take;
   assign s_axi_arready = ar_take;

   // writable fields go back to reset values while reset is low
   always_ff @(posedge core_clk) begin
      if (!rst_b || reset_line_low) begin
         aux_regulator_on <= CTRL_RST[CTRL_AUX_ON];
         drive_reg        <= DRIVE_RST;
      end else begin
         if (wr_ctrl && s_axi_wstrb[0]) begin
            aux_regulator_on <= s_axi_wdata[CTRL_AUX_ON];
         end
         if (wr_drive && s_axi_wstrb[0]) begin
            drive_reg[7:0] <= s_axi_wdata[7:0];
         end
         if (wr_drive && s_axi_wstrb[1]) begin
            drive_reg[15:8] <= s_axi_wdata[15:8];
         end
      end
   end

   // write response one cycle after the take
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (aw_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read data one cycle after the take
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************
   // bridges: 0,1 on driver 0; 2,3 on driver 1
   // ************************************************
   for (genvar b = 0; b < 4; b++) begin : g_br
      localparam int D = b / 2;          // driver index
      localparam int F = D * DRV_STRIDE + (b % 2) * PH_STRIDE;
      wire logic sel_lo = drive_reg[F + PH_LO];
      wire logic sel_hi = drive_reg[F + PH_HI];
      wire logic pol    = drive_reg[F + PH_POL];
      wire logic dc_dir = drive_reg[D * DRV_STRIDE + DRV_DC_DIR];
      wire logic step   = type_s[D];
      wire logic hot    = ot_s[D];
      wire logic lvl_off = sel_lo && sel_hi;
      logic [11:0] off_cnt;              // chopper off time left
      logic [7:0]  blank_cnt;            // blanking time left
      gate_t       gate_d;               // gates one cycle ago
      logic        g_hs_a;
      logic        g_ls_a;
      logic        g_hs_b;
      logic        g_ls_b;
      wire  gate_t gate = {g_hs_a, g_ls_a, g_hs_b, g_ls_b};
      wire  logic  chopping = (off_cnt != 12'h000);
      // open everything for zero level: diodes dump to supply
      wire gate_t step_want = (inhibit || hot || lvl_off || chopping)
         ? GATE_OFF
         : (pol ? GATE_REV : GATE_FWD);
      // dc: inhibit opens all; overtemperature or chop pin low brakes; else rotation bit
      wire gate_t dc_want = inhibit ? GATE_OFF :
         (hot || !chop_s[D]) ? GATE_BRAKE :
         (dc_dir ? GATE_FWD : GATE_REV);
      wire gate_t want = step ? step_want : dc_want;
      wire logic turn_on = |(gate & ~gate_d);
      // sense only counts once blanking has run out; the closing
      // cycle itself is blanked too, before the counter has loaded
      wire logic trip_hit = step && sense_s[b] && (want != GATE_OFF)
         && (blank_cnt == 8'h00) && !turn_on;

      half_gap u_half_a (
         .core_clk (core_clk),
         .rst_b    (rst_b),
         .want_hi  (want.hs_a),
         .want_lo  (want.ls_a),
         .hi       (g_hs_a),
         .lo       (g_ls_a)
      );
      half_gap u_half_b (
         .core_clk (core_clk),
         .rst_b    (rst_b),
         .want_hi  (want.hs_b),
         .want_lo  (want.ls_b),
         .hi       (g_hs_b),
         .lo       (g_ls_b)
      );
      assign bridge_gate[b] = gate;

      // blanking reloads on every switch closure
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            blank_cnt <= 8'h00;
            gate_d    <= GATE_OFF;
         end else begin
            gate_d <= gate;
            if (turn_on) begin
               blank_cnt <= BLANK_CYC;
            end else if (blank_cnt != 8'h00) begin
               blank_cnt <= blank_cnt - 8'h01;
            end
         end
      end

      // fixed off time after a trip; simple but ripple varies
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            off_cnt <= 12'h000;
         end else if (trip_hit) begin
            off_cnt <= CHOP_OFF_CYC;
         end else if (chopping) begin
            off_cnt <= off_cnt - 12'h001;
         end
      end

      // level code: 00 full, 01 two thirds, 10 one third
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            current_ref[2*b +: 2] <= 2'h0;
         end else if (step && !inhibit && !hot) begin
            current_ref[2*b +: 2] <= ~{sel_hi, sel_lo};
         end else begin
            current_ref[2*b +: 2] <= 2'h0;
         end
      end

      chk_off_level_idle: assert property (
         @(posedge core_clk) disable iff (!rst_b)
         step && lvl_off |-> want == GATE_OFF)
         else $error("stepper phase driven with level off");
      chk_blank_no_trip: assert property (
         @(posedge core_clk) disable iff (!rst_b)
         turn_on |-> !trip_hit [*8])
         else $error("sense acted inside blanking");
      chk_hot_step_zero: assert property (
         @(posedge core_clk) disable iff (!rst_b)
         step && hot |-> want == GATE_OFF ##1
         current_ref[2*b +: 2] == 2'h0)
         else $error("stepper not at zero current when hot");
      chk_hot_dc_high: assert property (
         @(posedge core_clk) disable iff (!rst_b)
         !step && hot && !inhibit |-> want == GATE_BRAKE)
         else $error("dc outputs not high when hot");
      chk_dc_table: assert property (
         @(posedge core_clk) disable iff (!rst_b)
         !step && !hot && !inhibit && chop_s[D] |->
         want == (dc_dir ? GATE_FWD : GATE_REV))
         else $error("dc bridge off its truth table");
      chk_inhibit_gates_off: assert property (
         @(posedge core_clk) disable iff (!rst_b)
         inhibit ##1 inhibit |-> gate == GATE_OFF)
         else $error("bridge conducting while inhibited");
      cov_step_trip: cover property (
         @(posedge core_clk) disable iff (!rst_b) trip_hit);
      cov_dc_drive: cover property (
         @(posedge core_clk) disable iff (!rst_b)
         !step && gate == GATE_FWD);
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   chk_vb_drop_reset: assert property (
      !sup_s.vb_ok |=> reset_pin_oe)
      else $error("motor supply low without reset");
   chk_release_delay: assert property (
      $fell(reset_pin_oe) |-> $past(delay_cnt) == RELEASE_DELAY_CYC)
      else $error("reset released before full delay");
   chk_dip_asserts: assert property (
      dip_hit |=> !v1_good ##1 reset_pin_oe)
      else $error("qualified dip did not assert reset");
   chk_aux_off_stop: assert property (
      !aux_regulator_on |=> ##1 bridge_gate == '0)
      else $error("drivers running with aux regulator off");
   cov_release: cover property ($fell(reset_pin_oe));
   cov_glitch: cover property (dip_hit ##1 !sup_s.v1_below_fall);
endmodule : motor_drive_reset_supervisor
`default_nettype wire

// [bench/host_model.sv]
// host side model: reset wire with pull-up, type straps, chop pins
`default_nettype none
module host_model (
   input  wire logic       reset_pin_out,
   input  wire logic       reset_pin_oe,
   input  wire logic       ext_pull,
   input  wire logic [1:0] type_cmd,
   input  wire logic [1:0] chop_cmd,
   output logic            reset_wire,
   output logic [1:0]      driver_type_select,
   output logic [1:0]      dc_chop_input
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-up wins unless the device or the host pulls low
   assign reset_wire =
      (reset_pin_oe ? reset_pin_out : 1'b1) & ~ext_pull;
   assign driver_type_select = type_cmd;
   assign dc_chop_input      = chop_cmd;
endmodule : host_model
`default_nettype wire

// [bench/test_motor_drive_reset_supervisor.sv]
// self-checking bench for the motor drive reset supervisor
`default_nettype none
module test_motor_drive_reset_supervisor
   import mdrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 0, rst_b = 0, ext_pull = 0;
   logic [7:0]  awaddr = 0, araddr = 0, cref;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, oe, pout, aux, wl;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0]  bresp, rresp, r, otemp = 0, tcmd = 2'h3, ccmd = 0, dts, chop;
   logic [3:0]  trip = 0;
   supply_t     sup = 4'hB; // logic supply up, motor supply good
   gate_t [3:0] gate;
   int          failures = 0, total_checks = 0;

   always #5 core_clk = ~core_clk;

   // short release delay keeps the run brief
   motor_drive_reset_supervisor #(.RELEASE_DELAY_CYC(50)) u_dut (
      .core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply(sup),
      .overtemp(otemp), .reset_pin_in(wl), .reset_pin_out(pout),
      .reset_pin_oe(oe), .driver_type_select(dts), .dc_chop_input(chop),
      .sense_trip(trip), .bridge_gate(gate), .current_ref(cref),
      .aux_regulator_on(aux));

   host_model u_host (.reset_pin_out(pout), .reset_pin_oe(oe),
      .ext_pull(ext_pull), .type_cmd(tcmd), .chop_cmd(ccmd),
      .reset_wire(wl), .driver_type_select(dts), .dc_chop_input(chop));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // write: address and data offered together, then wait for response
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do @(posedge core_clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b1;
      do @(posedge core_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   task automatic t_power();
      cyc(40);
      chk(32'(oe), 1);
      cyc(30);
      chk(32'(oe), 0);
   endtask : t_power

   task automatic t_regs();
      axr(ADDR_CTRL);
      chk(d, CTRL_RST);
      axr(ADDR_DRIVE);
      chk(d, 32'(DRIVE_RST));
      axr(8'h0C);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask : t_regs

   // every select code and both polarities on driver 0 phase A
   task automatic t_step();
      logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
      logic [1:0] lvl [5]  = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
      gate_t      g [5]    = '{GATE_FWD, GATE_FWD, GATE_FWD,
                               GATE_OFF, GATE_REV};
      for (int i = 0; i < 5; i++) begin
         axw(ADDR_DRIVE, {16'h0, 8'h1B, 5'h03, code[i]});
         cyc(30);
         chk(32'(gate[0]), 32'(g[i]));
         chk(32'(cref[1:0]), 32'(lvl[i]));
      end
      trip[0] <= 1'b1; // inside the blanking window
      cyc(5);
      chk(32'(gate[0]), 32'(GATE_REV));
      trip[0] <= 1'b0;
      otemp[0] <= 1'b1;
      cyc(5);
      chk(32'(cref[1:0]), 0);
      otemp[0] <= 1'b0;
      cyc(30);
      chk(32'(gate[0]), 32'(GATE_REV));
      cyc(100); // blanking from the re-close has run out
      trip[0] <= 1'b1;
      cyc(5);
      chk(32'(gate[0]), 32'(GATE_OFF));
      trip[0] <= 1'b0;
      cyc(2010); // chopper off time over, phase drives again
      chk(32'(gate[0]), 32'(GATE_REV));
   endtask : t_step

   // driver 1 as DC: brake, reverse, forward, then overheated
   task automatic t_dc();
      logic  rot [3] = '{1'b0, 1'b0, 1'b1};
      logic  pw [3]  = '{1'b0, 1'b1, 1'b1};
      gate_t g [3]   = '{GATE_BRAKE, GATE_REV, GATE_FWD};
      tcmd <= 2'h1;
      for (int i = 0; i < 3; i++) begin
         axw(ADDR_DRIVE, {16'h0, 1'b0, rot[i], 6'h1B, 8'h04});
         ccmd <= {pw[i], 1'b0};
         cyc(40);
         chk(32'(gate[3]), 32'(g[i]));
      end
      otemp[1] <= 1'b1;
      cyc(30);
      chk(32'(gate[2]), 32'(GATE_BRAKE));
      otemp[1] <= 1'b0;
   endtask : t_dc

   task automatic t_aux();
      axw(ADDR_CTRL, 32'h0);
      cyc(5);
      chk(32'(gate[0]), 32'(GATE_OFF));
      chk(32'(gate[3]), 32'(GATE_OFF));
      ext_pull <= 1'b1; // another party holds reset low
      cyc(10);
      chk(32'(aux), 1);
      ext_pull <= 1'b0;
      cyc(5);
      axr(ADDR_DRIVE);
      chk(d, 32'(DRIVE_RST));
   endtask : t_aux

   task automatic t_supply();
      sup.vb_ok <= 1'b0;
      cyc(6);
      chk(32'(oe), 1);
      chk(32'(gate[2]), 32'(GATE_OFF));
      sup.vb_ok <= 1'b1;
      cyc(6);
      chk(32'(oe), 0);
   endtask : t_supply

   // short dip is filtered, long dip gives a full release delay
   task automatic t_dip();
      sup <= 4'h7;
      cyc(1000);
      sup <= 4'hB;
      cyc(5);
      chk(32'(oe), 0);
      sup <= 4'h7;
      cyc(2100);
      chk(32'(oe), 1);
      sup <= 4'hB;
      cyc(30);
      chk(32'(oe), 1);
      cyc(40);
      chk(32'(oe), 0);
   endtask : t_dip

   task automatic summarize();
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   initial begin
      cyc(16);
      rst_b <= 1'b1;
      t_power();
      t_regs();
      t_step();
      t_dc();
      t_aux();
      t_supply();
      t_dip();
      summarize();
   end

   // watchdog: the whole sequence needs well under this span
   initial begin
      cyc(20000);
      failures++;
      summarize();
   end
endmodule : test_motor_drive_reset_supervisor
`default_nettype wire
